//--- core/mief_map.vh
// register map and field constants of the mac interrupt enable and frame limit block
`ifndef MIEF_MAP_VH
`define MIEF_MAP_VH

`define MIEF_ADDR_FRAME_LIMIT  32'hB00030A8
`define MIEF_ADDR_INT_ENABLE   32'hB00030AC
`define MIEF_ADDR_INT_STATUS   32'hB00030B0
`define MIEF_ADDR_EVT_STATUS   32'hB00030B4
`define MIEF_ADDR_EVT_MASK     32'hB00030B8

`define MIEF_FRAME_LIMIT_RST   16'h0800
`define MIEF_FRAME_LIMIT_W     16
`define MIEF_INT_ENABLE_RST    32'h00000000
`define MIEF_INT_STATUS_RST    32'h00000000
`define MIEF_INT_ENABLE_MASK   32'h01FF4FFF
`define MIEF_INT_STATUS_MASK   32'h01FE4FFE

`define MIEF_BIT_RX_MASTER     0
`define MIEF_BIT_OVERSIZE      8
`define MIEF_BIT_TX_MASTER     16
`define MIEF_TX_SRC_LO         17
`define MIEF_TX_SRC_HI         24
`define MIEF_RX_SRC_LO         1
`define MIEF_RX_SRC_HI         14
`define MIEF_BIT_CRC_ERROR       1
`define MIEF_BIT_RX_OVERFLOW     2
`define MIEF_BIT_TOO_LONG        3
`define MIEF_BIT_RX_GOOD         4
`define MIEF_BIT_ALIGN_ERROR     5
`define MIEF_BIT_RX_AUX6         6
`define MIEF_BIT_RX_AUX7         7
`define MIEF_BIT_DMA_EARLY       9
`define MIEF_BIT_RX_DESC_UNAVAIL 10
`define MIEF_BIT_RX_BUS_ERROR    11
`define MIEF_BIT_CTRL_FRAME      14
`define MIEF_BIT_TX_UNDERFLOW    17
`define MIEF_BIT_TX_COMPLETE     18
`define MIEF_BIT_DEFER_EXCEED    19
`define MIEF_BIT_NO_CARRIER      20
`define MIEF_BIT_TX_ABORT        21
`define MIEF_BIT_LATE_COLLISION  22
`define MIEF_BIT_TX_DESC_UNAVAIL 23
`define MIEF_BIT_TX_BUS_ERROR    24

`define MIEF_EVT_W             3
`define MIEF_EVT_OVERSIZE      0
`define MIEF_EVT_TX_IRQ_RISE   1
`define MIEF_EVT_RX_IRQ_RISE   2
`define MIEF_EVT_RST           3'h0

`endif

//--- core/mief_flag_bank.v
// bank of sticky flags, set wins over clear, unimplemented bits stay zero
`timescale 1ns/1ps
module mief_flag_bank #(
	parameter WIDTH = 32,
	parameter [WIDTH-1:0] IMPL = {WIDTH{1'b1}}
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire [WIDTH-1:0] set_in,
	input  wire [WIDTH-1:0] clr_in,
	output wire [WIDTH-1:0] flag_out
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
			if (IMPL[i]) begin : g_impl
				reg flag_q;
				always @(posedge clock) begin
					if (sys_rst)
						flag_q <= 1'b0;
					else
						flag_q <= set_in[i] | (flag_q & ~clr_in[i]);
				end
				assign flag_out[i] = flag_q;
			end else begin : g_none
				assign flag_out[i] = 1'b0;
			end
		end
	endgenerate
endmodule // mief_flag_bank

//--- core/mief_top.v
// mac interrupt enable, status gating and maximum receive frame length, apb slave
//
// How it works
// - 16-bit max_rx_frame_len in frame_limit_reg low bits, resets 0x0800.
// - frame longer than limit with oversize_int_en sets oversize_flag, raises rx interrupt when rx master enable bit 0 is set.
// - three cpu interrupt lines: receive summary, transmit summary and masked block event (evt_irq).
// - mac_int_enable_reg read-write at 0xB00030AC, all bits reset to zero.
// - tx source enables bits 24..17 gate their flags with tx master enable.
// - tx master enable bit 16 gates transmit summary; zero blocks tx interrupt.
// - rx source enables bits 14 and 11..1 gate flags with rx master enable.
// - enable zero masks its flag, one lets it take part.
// - rx master enable bit 0 gates receive summary; zero blocks rx interrupt.
// - writing one to mac_int_status_reg bit clears flag; zero leaves it.
// - any enabled tx flag asserts tx_summary_flag.
`timescale 1ns/1ps
`include "mief_map.vh"
module mief_top #(
	parameter LEN_W = `MIEF_FRAME_LIMIT_W
) (
	input  wire             clock,
	input  wire             sys_rst,
	input  wire             psel,
	input  wire             penable,
	input  wire             pwrite,
	input  wire [31:0]      paddr,
	input  wire [31:0]      pwdata,
	output wire [31:0]      prdata,
	output wire             pready,
	output wire             pslverr,
	input  wire [31:0]      status_evt,
	input  wire             rx_frame_done,
	input  wire [LEN_W-1:0] rx_frame_len,
	output wire             tx_irq,
	output wire             rx_irq,
	output wire             evt_irq
);
	// apb handshake, one wait state so read data comes from a flop
	reg              pready_q;
	reg              pslverr_q;
	reg  [31:0]      prdata_q;
	reg  [LEN_W-1:0] max_rx_frame_len_q;
	reg  [31:0]      mac_int_enable_q;
	reg  [`MIEF_EVT_W-1:0] evt_mask_q;
	reg              tx_irq_q;
	reg              rx_irq_q;
	reg              evt_irq_q;
	reg  [31:0]      rd_mux;
	reg              addr_hit;

	wire             acc_wait = psel & penable & ~pready_q;
	wire             acc_done = psel & penable & pready_q;
	wire             wr_done  = acc_done & pwrite & ~pslverr_q;
	wire             rd_done  = acc_done & ~pwrite & ~pslverr_q;

	wire             sel_limit  = (paddr == `MIEF_ADDR_FRAME_LIMIT);
	wire             sel_enable = (paddr == `MIEF_ADDR_INT_ENABLE);
	wire             sel_status = (paddr == `MIEF_ADDR_INT_STATUS);
	wire             sel_evt    = (paddr == `MIEF_ADDR_EVT_STATUS);
	wire             sel_emask  = (paddr == `MIEF_ADDR_EVT_MASK);

	// oversize frame detection
	wire             oversize_int_en = mac_int_enable_q[`MIEF_BIT_OVERSIZE];
	wire             frame_over      = rx_frame_done & (rx_frame_len > max_rx_frame_len_q);
	wire             oversize_set    = frame_over & oversize_int_en;

	// status flag bank
	wire [31:0]      st_set;
	wire [31:0]      st_clr;
	wire [31:0]      st_flags;
	wire [31:0]      st_view;
	wire             tx_summary_flag;
	wire             rx_summary_flag;

	assign st_set = (status_evt & `MIEF_INT_STATUS_MASK & ~(32'h00000001 << `MIEF_BIT_OVERSIZE))
		| ({31'h00000000, oversize_set} << `MIEF_BIT_OVERSIZE);
	assign st_clr = (wr_done & sel_status) ? pwdata : 32'h00000000;

	mief_flag_bank #(
		.WIDTH (32),
		.IMPL  (`MIEF_INT_STATUS_MASK)
	) u_status (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.set_in   (st_set),
		.clr_in   (st_clr),
		.flag_out (st_flags)
	);

	// transmit source flags
	wire             tx_bus_error_flag       = st_flags[`MIEF_BIT_TX_BUS_ERROR];
	wire             tx_desc_unavail_flag    = st_flags[`MIEF_BIT_TX_DESC_UNAVAIL];
	wire             late_collision_flag     = st_flags[`MIEF_BIT_LATE_COLLISION];
	wire             tx_abort_flag           = st_flags[`MIEF_BIT_TX_ABORT];
	wire             no_carrier_flag         = st_flags[`MIEF_BIT_NO_CARRIER];
	wire             defer_exceed_flag       = st_flags[`MIEF_BIT_DEFER_EXCEED];
	wire             tx_complete_flag        = st_flags[`MIEF_BIT_TX_COMPLETE];
	wire             tx_underflow_flag       = st_flags[`MIEF_BIT_TX_UNDERFLOW];

	// receive source flags
	wire             ctrl_frame_flag         = st_flags[`MIEF_BIT_CTRL_FRAME];
	wire             rx_bus_error_flag       = st_flags[`MIEF_BIT_RX_BUS_ERROR];
	wire             rx_desc_unavail_flag    = st_flags[`MIEF_BIT_RX_DESC_UNAVAIL];
	wire             dma_early_notify_flag   = st_flags[`MIEF_BIT_DMA_EARLY];
	wire             oversize_flag           = st_flags[`MIEF_BIT_OVERSIZE];
	wire             rx_aux7_flag            = st_flags[`MIEF_BIT_RX_AUX7];
	wire             rx_aux6_flag            = st_flags[`MIEF_BIT_RX_AUX6];
	wire             align_error_flag        = st_flags[`MIEF_BIT_ALIGN_ERROR];
	wire             rx_good_flag            = st_flags[`MIEF_BIT_RX_GOOD];
	wire             too_long_flag           = st_flags[`MIEF_BIT_TOO_LONG];
	wire             rx_overflow_flag        = st_flags[`MIEF_BIT_RX_OVERFLOW];
	wire             crc_error_flag          = st_flags[`MIEF_BIT_CRC_ERROR];

	// master enables
	wire             tx_master_int_en        = mac_int_enable_q[`MIEF_BIT_TX_MASTER];
	wire             rx_master_int_en        = mac_int_enable_q[`MIEF_BIT_RX_MASTER];

	// transmit source enables
	wire             tx_bus_error_int_en     = mac_int_enable_q[`MIEF_BIT_TX_BUS_ERROR];
	wire             tx_desc_unavail_int_en  = mac_int_enable_q[`MIEF_BIT_TX_DESC_UNAVAIL];
	wire             late_collision_int_en   = mac_int_enable_q[`MIEF_BIT_LATE_COLLISION];
	wire             tx_abort_int_en         = mac_int_enable_q[`MIEF_BIT_TX_ABORT];
	wire             no_carrier_int_en       = mac_int_enable_q[`MIEF_BIT_NO_CARRIER];
	wire             defer_exceed_int_en     = mac_int_enable_q[`MIEF_BIT_DEFER_EXCEED];
	wire             tx_complete_int_en      = mac_int_enable_q[`MIEF_BIT_TX_COMPLETE];
	wire             tx_underflow_int_en     = mac_int_enable_q[`MIEF_BIT_TX_UNDERFLOW];

	// receive source enables, oversize enable sits with the length compare
	wire             ctrl_frame_int_en       = mac_int_enable_q[`MIEF_BIT_CTRL_FRAME];
	wire             rx_bus_error_int_en     = mac_int_enable_q[`MIEF_BIT_RX_BUS_ERROR];
	wire             rx_desc_unavail_int_en  = mac_int_enable_q[`MIEF_BIT_RX_DESC_UNAVAIL];
	wire             dma_early_notify_int_en = mac_int_enable_q[`MIEF_BIT_DMA_EARLY];
	wire             rx_aux7_int_en          = mac_int_enable_q[`MIEF_BIT_RX_AUX7];
	wire             rx_aux6_int_en          = mac_int_enable_q[`MIEF_BIT_RX_AUX6];
	wire             align_error_int_en      = mac_int_enable_q[`MIEF_BIT_ALIGN_ERROR];
	wire             rx_good_int_en          = mac_int_enable_q[`MIEF_BIT_RX_GOOD];
	wire             too_long_int_en         = mac_int_enable_q[`MIEF_BIT_TOO_LONG];
	wire             rx_overflow_int_en      = mac_int_enable_q[`MIEF_BIT_RX_OVERFLOW];
	wire             crc_error_int_en        = mac_int_enable_q[`MIEF_BIT_CRC_ERROR];

	// each flag takes part only with its own enable
	wire             tx_bus_error_hit        = tx_bus_error_flag & tx_bus_error_int_en;
	wire             tx_desc_unavail_hit     = tx_desc_unavail_flag & tx_desc_unavail_int_en;
	wire             late_collision_hit      = late_collision_flag & late_collision_int_en;
	wire             tx_abort_hit            = tx_abort_flag & tx_abort_int_en;
	wire             no_carrier_hit          = no_carrier_flag & no_carrier_int_en;
	wire             defer_exceed_hit        = defer_exceed_flag & defer_exceed_int_en;
	wire             tx_complete_hit         = tx_complete_flag & tx_complete_int_en;
	wire             tx_underflow_hit        = tx_underflow_flag & tx_underflow_int_en;
	wire             ctrl_frame_hit          = ctrl_frame_flag & ctrl_frame_int_en;
	wire             rx_bus_error_hit        = rx_bus_error_flag & rx_bus_error_int_en;
	wire             rx_desc_unavail_hit     = rx_desc_unavail_flag & rx_desc_unavail_int_en;
	wire             dma_early_notify_hit    = dma_early_notify_flag & dma_early_notify_int_en;
	wire             oversize_hit            = oversize_flag & oversize_int_en;
	wire             rx_aux7_hit             = rx_aux7_flag & rx_aux7_int_en;
	wire             rx_aux6_hit             = rx_aux6_flag & rx_aux6_int_en;
	wire             align_error_hit         = align_error_flag & align_error_int_en;
	wire             rx_good_hit             = rx_good_flag & rx_good_int_en;
	wire             too_long_hit            = too_long_flag & too_long_int_en;
	wire             rx_overflow_hit         = rx_overflow_flag & rx_overflow_int_en;
	wire             crc_error_hit           = crc_error_flag & crc_error_int_en;

	// summaries, the masters are applied at the interrupt stage
	assign tx_summary_flag = tx_bus_error_hit
		| tx_desc_unavail_hit
		| late_collision_hit
		| tx_abort_hit
		| no_carrier_hit
		| defer_exceed_hit
		| tx_complete_hit
		| tx_underflow_hit;

	assign rx_summary_flag = ctrl_frame_hit
		| rx_bus_error_hit
		| rx_desc_unavail_hit
		| dma_early_notify_hit
		| oversize_hit
		| rx_aux7_hit
		| rx_aux6_hit
		| align_error_hit
		| rx_good_hit
		| too_long_hit
		| rx_overflow_hit
		| crc_error_hit;
	assign st_view = st_flags
		| ({31'h00000000, tx_summary_flag} << `MIEF_BIT_TX_MASTER)
		| ({31'h00000000, rx_summary_flag} << `MIEF_BIT_RX_MASTER);

	wire tx_irq_d = tx_summary_flag & tx_master_int_en;
	wire rx_irq_d = rx_summary_flag & rx_master_int_en;

	// block event register, cleared by read, set wins
	wire [`MIEF_EVT_W-1:0] evt_set;
	wire [`MIEF_EVT_W-1:0] evt_clr;
	wire [`MIEF_EVT_W-1:0] evt_flags;
	wire                   tx_irq_rise = tx_irq_d & ~tx_irq_q;
	wire                   rx_irq_rise = rx_irq_d & ~rx_irq_q;
	wire                   evt_rd_take = rd_done & sel_evt;

	assign evt_set[`MIEF_EVT_OVERSIZE]    = frame_over;
	assign evt_set[`MIEF_EVT_TX_IRQ_RISE] = tx_irq_rise;
	assign evt_set[`MIEF_EVT_RX_IRQ_RISE] = rx_irq_rise;
	// only bits already shown to software are cleared, a later event survives the read
	assign evt_clr = evt_rd_take ? prdata_q[`MIEF_EVT_W-1:0] : {`MIEF_EVT_W{1'b0}};

	mief_flag_bank #(
		.WIDTH (`MIEF_EVT_W),
		.IMPL  ({`MIEF_EVT_W{1'b1}})
	) u_events (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.set_in   (evt_set),
		.clr_in   (evt_clr),
		.flag_out (evt_flags)
	);

	// read mux
	always @* begin
		rd_mux   = 32'h00000000;
		addr_hit = 1'b1;
		case (1'b1)
			sel_limit:  rd_mux = {{(32-LEN_W){1'b0}}, max_rx_frame_len_q};
			sel_enable: rd_mux = mac_int_enable_q;
			sel_status: rd_mux = st_view;
			sel_evt:    rd_mux = {{(32-`MIEF_EVT_W){1'b0}}, evt_flags};
			sel_emask:  rd_mux = {{(32-`MIEF_EVT_W){1'b0}}, evt_mask_q};
			default:    addr_hit = 1'b0;
		endcase
	end

	// bus answer
	always @(posedge clock) begin
		if (sys_rst)
			pready_q <= 1'b0;
		else
			pready_q <= acc_wait;
	end

	always @(posedge clock) begin
		if (sys_rst)
			pslverr_q <= 1'b0;
		else
			pslverr_q <= acc_wait & ~addr_hit;
	end

	always @(posedge clock) begin
		if (sys_rst)
			prdata_q <= 32'h00000000;
		else if (acc_wait & ~pwrite & addr_hit)
			prdata_q <= rd_mux;
		else
			prdata_q <= 32'h00000000;
	end

	// software-written registers
	always @(posedge clock) begin
		if (sys_rst)
			max_rx_frame_len_q <= `MIEF_FRAME_LIMIT_RST;
		else if (wr_done & sel_limit)
			max_rx_frame_len_q <= pwdata[LEN_W-1:0];
	end

	always @(posedge clock) begin
		if (sys_rst)
			mac_int_enable_q <= `MIEF_INT_ENABLE_RST;
		else if (wr_done & sel_enable)
			mac_int_enable_q <= pwdata & `MIEF_INT_ENABLE_MASK;
	end

	always @(posedge clock) begin
		if (sys_rst)
			evt_mask_q <= `MIEF_EVT_RST;
		else if (wr_done & sel_emask)
			evt_mask_q <= pwdata[`MIEF_EVT_W-1:0];
	end

	// interrupt lines as registered levels
	always @(posedge clock) begin
		if (sys_rst)
			tx_irq_q <= 1'b0;
		else
			tx_irq_q <= tx_irq_d;
	end

	always @(posedge clock) begin
		if (sys_rst)
			rx_irq_q <= 1'b0;
		else
			rx_irq_q <= rx_irq_d;
	end

	always @(posedge clock) begin
		if (sys_rst)
			evt_irq_q <= 1'b0;
		else
			evt_irq_q <= |(evt_flags & evt_mask_q);
	end

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign tx_irq  = tx_irq_q;
	assign rx_irq  = rx_irq_q;
	assign evt_irq = evt_irq_q;
endmodule // mief_top

//--- bench/mief_top_monitor.sv
// assertion checker of the mac interrupt enable and frame limit block
`timescale 1ns/1ps
module mief_top_monitor (
	input wire        clock,
	input wire        sys_rst,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire        pready,
	input wire [31:0] status_evt,
	input wire        tx_irq,
	input wire        rx_irq
);
	logic [31:0] en_q;
	logic [31:0] en_dly_q;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	// shadow of the enable register and its value one cycle back
	always @(posedge clock) begin
		if (sys_rst) begin
			en_q     <= 32'h00000000;
			en_dly_q <= 32'h00000000;
		end else begin
			en_dly_q <= en_q;
			if (psel && penable && pready && pwrite && paddr == 32'hB00030AC)
				en_q <= pwdata & 32'h01FF4FFF;
		end
	end
	AST_TX_MASTER: assert property (!en_dly_q[16] |-> !tx_irq) else $error("tx irq without master");
	AST_RX_MASTER: assert property (!en_dly_q[0] |-> !rx_irq) else $error("rx irq without master");
	AST_TX_MASK: assert property (en_dly_q[24:17] == 8'h00 |-> !tx_irq) else $error("tx irq all masked");
	AST_RX_MASK: assert property (en_dly_q[14:1] == 14'h0000 |-> !rx_irq) else $error("rx irq all masked");
	AST_TX_RAISE: assert property (status_evt[18] ##1 (en_q[18] && en_q[16]) |=> tx_irq)
		else $error("tx irq missing");
	AST_RX_RAISE: assert property (status_evt[11] ##1 (en_q[11] && en_q[0]) |=> rx_irq)
		else $error("rx irq missing");
	AST_EN_READ: assert property (pready && !pwrite && paddr == 32'hB00030AC |-> prdata == en_q)
		else $error("enable readback wrong");
	AST_RSVD_ZERO: assert property (pready && !pwrite && paddr == 32'hB00030A8 |-> prdata[31:16] == 16'h0000)
		else $error("limit upper bits set");
endmodule // mief_top_monitor
bind mief_top mief_top_monitor u_mief_top_monitor (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .status_evt(status_evt),
	.tx_irq(tx_irq), .rx_irq(rx_irq));

//--- bench/mief_top_tb.sv
// self-checking bench of the mac interrupt enable and frame limit block
`timescale 1ns/1ps
module mief_top_tb;
	logic        clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rx_frame_done = 0, er;
	logic [31:0] paddr = 0, pwdata = 0, status_evt = 0, prdata, rd, v;
	logic [15:0] rx_frame_len = 0, lim;
	logic        pready, pslverr, tx_irq, rx_irq, evt_irq;
	int          fails = 0, compares = 0, cyc = 0, m;
	int          src[12] = '{17, 18, 19, 20, 21, 22, 23, 24, 14, 11, 10, 9};
	mief_top u_mief_top (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_evt(status_evt),
		.rx_frame_done(rx_frame_done), .rx_frame_len(rx_frame_len), .tx_irq(tx_irq), .rx_irq(rx_irq), .evt_irq(evt_irq));
	initial forever #4 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			wrap_up();
		end
	end
	task chk(input [31:0] s, input [31:0] x);
		compares++;
		if (s !== x) begin
			fails++;
			$display("Error %0t: got %h expected %h", $time, s, x);
		end
	endtask
	task wrap_up;
		if (fails == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task apb(input w, input [31:0] a, input [31:0] d);
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task pulse(input [31:0] e, input [15:0] l, input d);
		@(posedge clock);
		status_evt <= e;
		rx_frame_len <= l;
		rx_frame_done <= d;
		@(posedge clock);
		status_evt <= 0;
		rx_frame_done <= 0;
		repeat (3) @(posedge clock);
	endtask
	function logic irq(int b);
		return b > 16 ? tx_irq : rx_irq;
	endfunction
	initial begin
		v = $urandom(32'hCFAF4B5C);
		repeat (6) @(posedge clock);
		sys_rst <= 0;
		apb(0, 32'hB00030A8, 0);
		chk(rd, 32'h00000800);
		apb(0, 32'hB00030AC, 0);
		chk(rd, 32'h00000000);
		v = $urandom;
		apb(1, 32'hB00030AC, v);
		apb(0, 32'hB00030AC, 0);
		chk(rd, v & 32'h01FF4FFF);
		apb(0, 32'hB00030C0, 0);
		chk(er, 1);
		foreach (src[i]) begin
			m = src[i] > 16 ? 16 : 0;
			pulse(1 << src[i], 0, 0);
			apb(1, 32'hB00030AC, 1 << src[i]);
			pulse(0, 0, 0);
			chk(irq(src[i]), 0);
			apb(1, 32'hB00030AC, (1 << src[i]) | (1 << m));
			pulse(0, 0, 0);
			chk(irq(src[i]), 1);
			apb(0, 32'hB00030B0, 0);
			chk(rd[m], 1);
			apb(1, 32'hB00030AC, ($urandom & ~(32'h1 << src[i])) | (1 << m));
			pulse(0, 0, 0);
			chk(irq(src[i]), 0);
			apb(1, 32'hB00030B0, ~(32'h1 << src[i]));
			apb(1, 32'hB00030AC, (1 << src[i]) | (1 << m));
			pulse(0, 0, 0);
			chk(irq(src[i]), 1);
			apb(1, 32'hB00030B0, 1 << src[i]);
			pulse(0, 0, 0);
			chk(irq(src[i]), 0);
			pulse(1 << src[i], 0, 0);
			chk(irq(src[i]), 1);
			apb(1, 32'hB00030B0, 1 << src[i]);
		end
		lim = 16'd1519 + 16'($urandom % 2000);
		apb(1, 32'hB00030A8, {16'hFFFF, lim});
		apb(0, 32'hB00030A8, 0);
		chk(rd, {16'h0000, lim});
		apb(1, 32'hB00030AC, 32'h00000101);
		pulse(0, lim, 1);
		chk(rx_irq, 0);
		pulse(0, lim + 16'd1, 1);
		chk(rx_irq, 1);
		chk(evt_irq, 0);
		apb(1, 32'hB00030B8, 1);
		pulse(0, 0, 0);
		chk(evt_irq, 1);
		apb(0, 32'hB00030B4, 0);
		chk(rd, 32'h00000007);
		pulse(0, 0, 0);
		chk(evt_irq, 0);
		wrap_up();
	end
endmodule // mief_top_tb
